// [pmrs_top.sv]
// Function
// - Drive bit: clear push-pull, set open-drain
// - Direction/pull codes: none, up, down, output
// - Direction/pull resets to input pull-down
// - Analog mode ignores direction/pull field
// - Port zero rail: only bits six, seven
// - Ports one, three, four: eight rail bits
// - Port two: five rail bits, rest reserved
// - Rail bit one selects 1.8 V rail
// - Rail bits reset to zero, 3.3 V
`timescale 1ns/100ps
`default_nettype none
`include "pmrs_defs.svh"

module pmrs_top
  import pmrs_pkg::*;
(
  input  wire logic        CORE_CLK_I,         // Bus clock, 25 MHz
  input  wire logic        RST_B_I,            // Sync reset, low
  input  wire logic        PSEL_I,             // APB select
  input  wire logic        PENABLE_I,          // APB enable
  input  wire logic        PWRITE_I,           // APB direction
  input  wire logic [11:0] PADDR_I,            // APB byte address
  input  wire logic [31:0] PWDATA_I,           // APB write data
  input  wire logic [3:0]  PSTRB_I,            // APB byte strobes
  input  wire logic [1:0]  ADC_MODE_I,         // Analog mode, pins 4.6/4.7
  output logic             PREADY_O,           // APB ready
  output logic             PSLVERR_O,          // APB error
  output logic      [31:0] PRDATA_O,           // APB read data
  output pmrs_pad_ctrl_t   PIN46_PAD_O,        // Pad 4.6 controls
  output pmrs_pad_ctrl_t   PIN47_PAD_O,        // Pad 4.7 controls
  output logic      [1:0]  PORT0_RAIL_BITS_O,  // Pins 0.6, 0.7 rail
  output logic      [7:0]  PORT1_RAIL_BITS_O,  // Port 1 rail
  output logic      [4:0]  PORT2_RAIL_BITS_O,  // Port 2 rail
  output logic      [7:0]  PORT3_RAIL_BITS_O,  // Port 3 rail
  output logic      [7:0]  PORT4_RAIL_BITS_O   // Port 4 rail
);

  // Register indexes
  localparam logic [31:0] IDX_PIN46 = `PMRS_IDX_PIN46_MODE;
  localparam logic [31:0] IDX_PIN47 = `PMRS_IDX_PIN47_MODE;
  localparam logic [31:0] IDX_RAIL0 = `PMRS_IDX_PORT0_RAIL;
  localparam logic [31:0] IDX_RAIL1 = `PMRS_IDX_PORT1_RAIL;
  localparam logic [31:0] IDX_RAIL2 = `PMRS_IDX_PORT2_RAIL;
  localparam logic [31:0] IDX_RAIL3 = `PMRS_IDX_PORT3_RAIL;
  localparam logic [31:0] IDX_RAIL4 = `PMRS_IDX_PORT4_RAIL;

  localparam int NREG = 7;

  // Register slot numbers
  localparam int SLOT_PIN46 = 0;
  localparam int SLOT_PIN47 = 1;
  localparam int SLOT_RAIL0 = 2;
  localparam int SLOT_RAIL1 = 3;
  localparam int SLOT_RAIL2 = 4;
  localparam int SLOT_RAIL3 = 5;
  localparam int SLOT_RAIL4 = 6;

  pmrs_top_t st_ff;
  pmrs_top_t nxt_st;

  logic [`PMRS_IDX_W-1:0] word_idx;
  logic [NREG-1:0]        hit;
  logic                   mapped;
  logic                   setup_ph;
  logic                   wr_acc;
  logic [NREG-1:0]        wr_en;
  logic [15:0]            rd_word [NREG];
  logic [15:0]            rd_sel;
  pmrs_mode_t             mode46;
  pmrs_mode_t             mode47;
  logic [7:0]             rail0;
  logic [7:0]             rail1;
  logic [7:0]             rail2;
  logic [7:0]             rail3;
  logic [7:0]             rail4;

  // Address decode, one aligned word per register
  assign word_idx = PADDR_I[`PMRS_IDX_W+1:2];

  always_comb begin
    hit             = '0;
    hit[SLOT_PIN46] = (word_idx == IDX_PIN46[`PMRS_IDX_W-1:0]);
    hit[SLOT_PIN47] = (word_idx == IDX_PIN47[`PMRS_IDX_W-1:0]);
    hit[SLOT_RAIL0] = (word_idx == IDX_RAIL0[`PMRS_IDX_W-1:0]);
    hit[SLOT_RAIL1] = (word_idx == IDX_RAIL1[`PMRS_IDX_W-1:0]);
    hit[SLOT_RAIL2] = (word_idx == IDX_RAIL2[`PMRS_IDX_W-1:0]);
    hit[SLOT_RAIL3] = (word_idx == IDX_RAIL3[`PMRS_IDX_W-1:0]);
    hit[SLOT_RAIL4] = (word_idx == IDX_RAIL4[`PMRS_IDX_W-1:0]);
  end

  assign mapped   = |hit;
  assign setup_ph = PSEL_I && !PENABLE_I;

  // Write lands only on the access edge the master samples
  assign wr_acc = PSEL_I && PENABLE_I && st_ff.pready && PWRITE_I;
  assign wr_en  = wr_acc ? hit : '0;

  // Pin mode registers
  pmrs_pin_mode u_pin46 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_PIN46]),
    .strb_i  (PSTRB_I[1:0]),
    .wdata_i (PWDATA_I[15:0]),
    .mode_o  (mode46),
    .rdata_o (rd_word[SLOT_PIN46])
  );

  pmrs_pin_mode u_pin47 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_PIN47]),
    .strb_i  (PSTRB_I[1:0]),
    .wdata_i (PWDATA_I[15:0]),
    .mode_o  (mode47),
    .rdata_o (rd_word[SLOT_PIN47])
  );

  // Rail select registers, masks leave reserved bits at zero
  pmrs_rail_reg #(
    .MASK (`PMRS_RAIL0_MASK)
  ) u_rail0 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_RAIL0]),
    .strb_i  (PSTRB_I[0]),
    .wdata_i (PWDATA_I[15:0]),
    .bits_o  (rail0),
    .rdata_o (rd_word[SLOT_RAIL0])
  );

  pmrs_rail_reg #(
    .MASK (`PMRS_RAIL1_MASK)
  ) u_rail1 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_RAIL1]),
    .strb_i  (PSTRB_I[0]),
    .wdata_i (PWDATA_I[15:0]),
    .bits_o  (rail1),
    .rdata_o (rd_word[SLOT_RAIL1])
  );

  pmrs_rail_reg #(
    .MASK (`PMRS_RAIL2_MASK)
  ) u_rail2 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_RAIL2]),
    .strb_i  (PSTRB_I[0]),
    .wdata_i (PWDATA_I[15:0]),
    .bits_o  (rail2),
    .rdata_o (rd_word[SLOT_RAIL2])
  );

  pmrs_rail_reg #(
    .MASK (`PMRS_RAIL3_MASK)
  ) u_rail3 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_RAIL3]),
    .strb_i  (PSTRB_I[0]),
    .wdata_i (PWDATA_I[15:0]),
    .bits_o  (rail3),
    .rdata_o (rd_word[SLOT_RAIL3])
  );

  pmrs_rail_reg #(
    .MASK (`PMRS_RAIL4_MASK)
  ) u_rail4 (
    .clk_i   (CORE_CLK_I),
    .rst_b_i (RST_B_I),
    .wr_en_i (wr_en[SLOT_RAIL4]),
    .strb_i  (PSTRB_I[0]),
    .wdata_i (PWDATA_I[15:0]),
    .bits_o  (rail4),
    .rdata_o (rd_word[SLOT_RAIL4])
  );

  // Read mux, one hot select
  always_comb begin
    rd_sel = '0;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_sel = rd_sel | rd_word[i];
      end
    end
  end

  // Pad control decode for one pin
  function automatic pmrs_pad_ctrl_t pad_decode(input pmrs_mode_t m, input logic adc);
    pmrs_pad_ctrl_t p;
    p              = '0;
    p.function_sel = m.function_sel;
    p.open_drain   = m.drive_type_sel;
    p.analog_en    = adc;
    if (!adc) begin
      unique case (m.dir_pull_sel)
        PMRS_DP_IN_NONE: begin
          p.out_en = 1'b0;
        end
        PMRS_DP_IN_UP: begin
          p.pull_up_en = 1'b1;
        end
        PMRS_DP_IN_DOWN: begin
          p.pull_dn_en = 1'b1;
        end
        PMRS_DP_OUT: begin
          p.out_en = 1'b1;
        end
      endcase
    end
    return p;
  endfunction

  // Next state of bus answer and pad outputs
  always_comb begin
    nxt_st = st_ff;

    // Answer is ready in the cycle after setup
    nxt_st.pready  = setup_ph;
    nxt_st.pslverr = setup_ph && !mapped;
    if (setup_ph) begin
      nxt_st.prdata = (!PWRITE_I && mapped) ? {16'h0000, rd_sel} : '0;
    end

    nxt_st.pad46 = pad_decode(mode46, ADC_MODE_I[0]);
    nxt_st.pad47 = pad_decode(mode47, ADC_MODE_I[1]);

    // A set bit powers the pin from pad_rail_1v8, clear from pad_rail_3v3
    nxt_st.port0_rail_bits = rail0[7:6];
    nxt_st.port1_rail_bits = rail1;
    nxt_st.port2_rail_bits = rail2[4:0];
    nxt_st.port3_rail_bits = rail3;
    nxt_st.port4_rail_bits = rail4;
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_B_I) begin
      st_ff.pready          <= 1'b0;
      st_ff.pslverr         <= 1'b0;
      st_ff.prdata          <= '0;
      // Matches the reset content of the mode registers
      st_ff.pad46           <= '{analog_en: 1'b0, out_en: 1'b0, open_drain: 1'b0,
                                 pull_up_en: 1'b0, pull_dn_en: 1'b1, function_sel: 6'h00};
      st_ff.pad47           <= '{analog_en: 1'b0, out_en: 1'b0, open_drain: 1'b0,
                                 pull_up_en: 1'b0, pull_dn_en: 1'b1, function_sel: 6'h00};
      st_ff.port0_rail_bits <= '0;
      st_ff.port1_rail_bits <= '0;
      st_ff.port2_rail_bits <= '0;
      st_ff.port3_rail_bits <= '0;
      st_ff.port4_rail_bits <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign PREADY_O          = st_ff.pready;
  assign PSLVERR_O         = st_ff.pslverr;
  assign PRDATA_O          = st_ff.prdata;
  assign PIN46_PAD_O       = st_ff.pad46;
  assign PIN47_PAD_O       = st_ff.pad47;
  assign PORT0_RAIL_BITS_O = st_ff.port0_rail_bits;
  assign PORT1_RAIL_BITS_O = st_ff.port1_rail_bits;
  assign PORT2_RAIL_BITS_O = st_ff.port2_rail_bits;
  assign PORT3_RAIL_BITS_O = st_ff.port3_rail_bits;
  assign PORT4_RAIL_BITS_O = st_ff.port4_rail_bits;

endmodule // pmrs_top
`default_nettype wire

// [pmrs_defs.svh]
`ifndef PMRS_DEFS_SVH
`define PMRS_DEFS_SVH

// APB geometry
`define PMRS_ADDR_W        12
`define PMRS_DATA_W        32
`define PMRS_REG_W         16
`define PMRS_IDX_W         10

// Register indexes, byte address is four times the low index bits
`define PMRS_IDX_PIN46_MODE  32'h5000_306A
`define PMRS_IDX_PIN47_MODE  32'h5000_306C
`define PMRS_IDX_PORT0_RAIL  32'h5000_30C0
`define PMRS_IDX_PORT1_RAIL  32'h5000_30C2
`define PMRS_IDX_PORT2_RAIL  32'h5000_30C4
`define PMRS_IDX_PORT3_RAIL  32'h5000_30C6
`define PMRS_IDX_PORT4_RAIL  32'h5000_30C8

// Pin mode register fields
`define PMRS_MODE_DRV_BIT    10
`define PMRS_MODE_DP_MSB     9
`define PMRS_MODE_DP_LSB     8
`define PMRS_MODE_FUNC_MSB   5
`define PMRS_MODE_FUNC_LSB   0
`define PMRS_MODE_DRV_RST    1'h0
`define PMRS_MODE_DP_RST     2'h2
`define PMRS_MODE_FUNC_RST   6'h00

// Rail select fields, implemented bits per port
`define PMRS_RAIL_MSB        7
`define PMRS_RAIL_LSB        0
`define PMRS_RAIL_RST        8'h00
`define PMRS_RAIL0_MASK      8'hC0
`define PMRS_RAIL1_MASK      8'hFF
`define PMRS_RAIL2_MASK      8'h1F
`define PMRS_RAIL3_MASK      8'hFF
`define PMRS_RAIL4_MASK      8'hFF

`endif

// [pmrs_pkg.sv]
package pmrs_pkg;

  // Direction and pull codes, ascending
  typedef enum logic [1:0] {
    PMRS_DP_IN_NONE = 2'h0,
    PMRS_DP_IN_UP   = 2'h1,
    PMRS_DP_IN_DOWN = 2'h2,
    PMRS_DP_OUT     = 2'h3
  } pmrs_dir_pull_t;

  typedef struct packed {
    logic           drive_type_sel;
    pmrs_dir_pull_t dir_pull_sel;
    logic [5:0]     function_sel;
  } pmrs_mode_t;

  typedef struct packed {
    logic [7:0] rail_bits;
  } pmrs_rail_t;

  // Controls seen by one pad cell
  typedef struct packed {
    logic       analog_en;
    logic       out_en;
    logic       open_drain;
    logic       pull_up_en;
    logic       pull_dn_en;
    logic [5:0] function_sel;
  } pmrs_pad_ctrl_t;

  typedef struct packed {
    logic           pready;
    logic           pslverr;
    logic [31:0]    prdata;
    pmrs_pad_ctrl_t pad46;
    pmrs_pad_ctrl_t pad47;
    logic [1:0]     port0_rail_bits;
    logic [7:0]     port1_rail_bits;
    logic [4:0]     port2_rail_bits;
    logic [7:0]     port3_rail_bits;
    logic [7:0]     port4_rail_bits;
  } pmrs_top_t;

endpackage

// [pmrs_pin_mode.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmrs_defs.svh"

module pmrs_pin_mode
  import pmrs_pkg::*;
(
  input  wire logic        clk_i,    // Bus clock
  input  wire logic        rst_b_i,  // Sync reset, low
  input  wire logic        wr_en_i,  // Write strobe
  input  wire logic [1:0]  strb_i,   // Byte lanes
  input  wire logic [15:0] wdata_i,  // Write data
  output pmrs_mode_t       mode_o,   // Stored fields
  output logic      [15:0] rdata_o   // Readback
);

  pmrs_mode_t st_ff;
  pmrs_mode_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en_i && strb_i[1]) begin
      nxt_st.drive_type_sel = wdata_i[`PMRS_MODE_DRV_BIT];
      nxt_st.dir_pull_sel   = pmrs_dir_pull_t'(wdata_i[`PMRS_MODE_DP_MSB:`PMRS_MODE_DP_LSB]);
    end
    if (wr_en_i && strb_i[0]) begin
      nxt_st.function_sel = wdata_i[`PMRS_MODE_FUNC_MSB:`PMRS_MODE_FUNC_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff.drive_type_sel <= `PMRS_MODE_DRV_RST;
      st_ff.dir_pull_sel   <= pmrs_dir_pull_t'(`PMRS_MODE_DP_RST);
      st_ff.function_sel   <= `PMRS_MODE_FUNC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    rdata_o = '0;
    rdata_o[`PMRS_MODE_DRV_BIT]                    = st_ff.drive_type_sel;
    rdata_o[`PMRS_MODE_DP_MSB:`PMRS_MODE_DP_LSB]   = st_ff.dir_pull_sel;
    rdata_o[`PMRS_MODE_FUNC_MSB:`PMRS_MODE_FUNC_LSB] = st_ff.function_sel;
  end

  assign mode_o = st_ff;

endmodule // pmrs_pin_mode
`default_nettype wire

// [pmrs_rail_reg.sv]
`timescale 1ns/100ps
`default_nettype none
`include "pmrs_defs.svh"

module pmrs_rail_reg
  import pmrs_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hFF  // Implemented bits
) (
  input  wire logic        clk_i,    // Bus clock
  input  wire logic        rst_b_i,  // Sync reset, low
  input  wire logic        wr_en_i,  // Write strobe
  input  wire logic        strb_i,   // Low byte lane
  input  wire logic [15:0] wdata_i,  // Write data
  output logic      [7:0]  bits_o,   // One bit per pin
  output logic      [15:0] rdata_o   // Readback
);

  pmrs_rail_t st_ff;
  pmrs_rail_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en_i && strb_i) begin
      nxt_st.rail_bits = wdata_i[`PMRS_RAIL_MSB:`PMRS_RAIL_LSB] & MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st_ff.rail_bits <= `PMRS_RAIL_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bits_o  = st_ff.rail_bits;
  assign rdata_o = {8'h00, st_ff.rail_bits};

endmodule // pmrs_rail_reg
`default_nettype wire

// [pmrs_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module pmrs_top_asserts
  import pmrs_pkg::*;
(
  input wire logic           CORE_CLK_I,         // Clock
  input wire logic           RST_B_I,            // Reset
  input wire logic           PSEL_I,             // Select
  input wire logic           PENABLE_I,          // Enable
  input wire logic           PWRITE_I,           // Direction
  input wire logic    [11:0] PADDR_I,            // Address
  input wire logic    [31:0] PWDATA_I,           // Write data
  input wire logic    [3:0]  PSTRB_I,            // Strobes
  input wire logic    [1:0]  ADC_MODE_I,         // Analog mode
  input wire logic           PREADY_O,           // Ready
  input wire logic           PSLVERR_O,          // Error
  input wire logic    [31:0] PRDATA_O,           // Read data
  input wire pmrs_pad_ctrl_t PIN46_PAD_O,        // Pad 4.6
  input wire pmrs_pad_ctrl_t PIN47_PAD_O,        // Pad 4.7
  input wire logic    [1:0]  PORT0_RAIL_BITS_O,  // Port 0 rail
  input wire logic    [7:0]  PORT1_RAIL_BITS_O,  // Port 1 rail
  input wire logic    [4:0]  PORT2_RAIL_BITS_O,  // Port 2 rail
  input wire logic    [7:0]  PORT3_RAIL_BITS_O,  // Port 3 rail
  input wire logic    [7:0]  PORT4_RAIL_BITS_O   // Port 4 rail
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  logic wr_acc;
  logic rd_acc;
  assign wr_acc = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;
  assign rd_acc = PSEL_I && PENABLE_I && PREADY_O && !PWRITE_I;

  a_reset_state: assert property (
    !$past(RST_B_I) |-> PIN46_PAD_O == 11'h040 && PIN47_PAD_O == 11'h040 &&
    {PORT0_RAIL_BITS_O, PORT1_RAIL_BITS_O, PORT2_RAIL_BITS_O, PORT3_RAIL_BITS_O, PORT4_RAIL_BITS_O} == 31'h0)
    else $error("state after reset wrong");
  a_drive_type: assert property (
    wr_acc && PADDR_I == 12'h1A8 && PSTRB_I[1] |-> ##2 PIN46_PAD_O.open_drain == $past(PWDATA_I[10], 2))
    else $error("drive type not applied");
  a_dir_pull_code: assert property (
    wr_acc && PADDR_I == 12'h1B0 && PSTRB_I[1] ##1 !ADC_MODE_I[1] |=>
    {PIN47_PAD_O.out_en, PIN47_PAD_O.pull_up_en, PIN47_PAD_O.pull_dn_en} ==
    {$past(PWDATA_I[9:8], 2) == 2'h3, $past(PWDATA_I[9:8], 2) == 2'h1, $past(PWDATA_I[9:8], 2) == 2'h2})
    else $error("direction and pull decode wrong");
  a_analog_force: assert property (
    $past(RST_B_I) && $past(ADC_MODE_I[0]) |-> PIN46_PAD_O.analog_en && !PIN46_PAD_O.out_en &&
    !PIN46_PAD_O.pull_up_en && !PIN46_PAD_O.pull_dn_en)
    else $error("analog mode not forcing pad");
  a_func_route: assert property (
    wr_acc && PADDR_I == 12'h1A8 && PSTRB_I[0] |-> ##2 PIN46_PAD_O.function_sel == $past(PWDATA_I[5:0], 2))
    else $error("function select not routed");
  a_port0_rail: assert property (
    wr_acc && PADDR_I == 12'h300 && PSTRB_I[0] |-> ##2 PORT0_RAIL_BITS_O == $past(PWDATA_I[7:6], 2))
    else $error("port 0 rail wrong");
  a_port1_rail: assert property (
    wr_acc && PADDR_I == 12'h308 && PSTRB_I[0] |-> ##2 PORT1_RAIL_BITS_O == $past(PWDATA_I[7:0], 2))
    else $error("port 1 rail wrong");
  a_port2_rail: assert property (
    wr_acc && PADDR_I == 12'h310 && PSTRB_I[0] |-> ##2 PORT2_RAIL_BITS_O == $past(PWDATA_I[4:0], 2))
    else $error("port 2 rail wrong");
  a_port4_rail: assert property (
    wr_acc && PADDR_I == 12'h320 && PSTRB_I[0] |-> ##2 PORT4_RAIL_BITS_O == $past(PWDATA_I[7:0], 2))
    else $error("port 4 rail wrong");
  a_read_reserved: assert property (
    rd_acc |-> PRDATA_O[31:16] == 16'h0000 && (PADDR_I != 12'h310 || PRDATA_O[15:5] == 11'h000) &&
    (PADDR_I != 12'h1A8 || (PRDATA_O[15:11] == 5'h00 && PRDATA_O[7:6] == 2'h0)))
    else $error("reserved bits read nonzero");
endmodule // pmrs_top_asserts
`default_nettype wire

// [tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb
  import pmrs_pkg::*;
;
  logic           clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic    [11:0] paddr;
  logic    [31:0] pwdata, prdata;
  logic    [3:0]  pstrb;
  logic    [1:0]  adc_mode, port0_rail;
  pmrs_pad_ctrl_t pad46, pad47;
  logic    [7:0]  port1_rail, port3_rail, port4_rail;
  logic    [4:0]  port2_rail;
  int             num_errors = 0;
  int             tests_run = 0;
  logic    [11:0] rail_addr [5] = '{12'h300, 12'h308, 12'h310, 12'h318, 12'h320};
  logic    [7:0]  rail_mask [5] = '{8'hC0, 8'hFF, 8'h1F, 8'hFF, 8'hFF};

  pmrs_top i_pmrs_top (.CORE_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .ADC_MODE_I(adc_mode),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PRDATA_O(prdata), .PIN46_PAD_O(pad46), .PIN47_PAD_O(pad47),
    .PORT0_RAIL_BITS_O(port0_rail), .PORT1_RAIL_BITS_O(port1_rail), .PORT2_RAIL_BITS_O(port2_rail),
    .PORT3_RAIL_BITS_O(port3_rail), .PORT4_RAIL_BITS_O(port4_rail));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Outputs follow a written register one edge later
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b1, d, s, rd, err);
    settle();
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(a, 1'b0, 32'h0000_0000, 4'h0, rd, err);
    chk(name, rd, exp);
  endtask

  function automatic logic [31:0] rail_out(input int p);
    case (p)
      0: return {24'h0, port0_rail, 6'h0};
      1: return {24'h0, port1_rail};
      2: return {27'h0, port2_rail};
      3: return {24'h0, port3_rail};
      default: return {24'h0, port4_rail};
    endcase
  endfunction

  task automatic t_reset;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (15) @(posedge clk);
    rst_b <= 1'b1;
    chk("pad46 reset", {21'h0, pad46}, 32'h0000_0040);
    chk("pad47 reset", {21'h0, pad47}, 32'h0000_0040);
    rd_chk("pin46 reset", 12'h1A8, 32'h0000_0200);
    rd_chk("pin47 reset", 12'h1B0, 32'h0000_0200);
    for (int p = 0; p < 5; p++) begin
      chk("rail out reset", rail_out(p), 32'h0000_0000);
      rd_chk("rail reset", rail_addr[p], 32'h0000_0000);
    end
    $display("Test reset done");
  endtask

  task automatic t_rails;
    logic [31:0] pat [3] = '{32'hFFFF_FFFF, 32'h0000_A5A5, 32'h0000_0000};
    logic [31:0] exp;
    for (int k = 0; k < 3; k++) begin
      for (int p = 0; p < 5; p++) begin
        wr(rail_addr[p], pat[k], 4'hF);
        exp = {24'h0, pat[k][7:0] & rail_mask[p]};
        chk("rail out", rail_out(p), exp);
        rd_chk("rail read", rail_addr[p], exp);
      end
    end
    $display("Test rails done");
  endtask

  task automatic t_mode;
    logic [1:0]     c;
    logic [5:0]     f;
    pmrs_pad_ctrl_t exp;
    for (int i = 0; i < 2; i++) begin
      for (int k = 0; k < 4; k++) begin
        c = 2'(k);
        f = {c, ~c, c};
        wr(12'h1A8 + 12'(8 * i), {16'hFFFF, 5'h1F, c[0], c, 2'h3, f}, 4'hF);
        exp = '{1'b0, c == 2'h3, c[0], c == 2'h1, c == 2'h2, f};
        chk("pad ctrl", {21'h0, i ? pad47 : pad46}, {21'h0, exp});
        rd_chk("mode read", 12'h1A8 + 12'(8 * i), {21'h0, c[0], c, 2'h0, f});
      end
    end
    $display("Test mode done");
  endtask

  task automatic t_strobe;
    logic [31:0] rd;
    logic        err;
    wr(12'h1A8, 32'h0000_0000, 4'h1);
    rd_chk("low lane only", 12'h1A8, 32'h0000_0700);
    chk("low lane pad", {21'h0, pad46}, 32'h0000_0300);
    wr(12'h1A8, 32'h0000_0000, 4'h2);
    wr(12'h1A8, 32'hFFFF_FFFF, 4'h0);
    rd_chk("no lanes", 12'h1A8, 32'h0000_0000);
    wr(12'h308, 32'h0000_00FF, 4'h2);
    chk("rail high lane", rail_out(1), 32'h0000_0000);
    apb(12'h1AC, 1'b0, 32'h0000_0000, 4'h0, rd, err);
    chk("unmapped rd err", {31'h0, err}, 32'h0000_0001);
    chk("unmapped rd data", rd, 32'h0000_0000);
    apb(12'h304, 1'b1, 32'hFFFF_FFFF, 4'hF, rd, err);
    chk("unmapped wr err", {31'h0, err}, 32'h0000_0001);
    settle();
    chk("rail0 untouched", rail_out(0), 32'h0000_0000);
    $display("Test strobe done");
  endtask

  task automatic t_adc;
    wr(12'h1A8, 32'h0000_0300, 4'hF);
    wr(12'h1B0, 32'h0000_0500, 4'hF);
    @(posedge clk);
    adc_mode <= 2'h3;
    settle();
    chk("adc pad46", {21'h0, pad46}, 32'h0000_0400);
    chk("adc pad47", {21'h0, pad47}, 32'h0000_0500);
    rd_chk("adc field kept", 12'h1A8, 32'h0000_0300);
    adc_mode <= 2'h0;
    settle();
    chk("pad46 output", {21'h0, pad46}, 32'h0000_0200);
    chk("pad47 pull-up", {21'h0, pad47}, 32'h0000_0180);
    $display("Test adc done");
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    adc_mode = 2'h0;
    t_reset();
    t_rails();
    t_mode();
    t_strobe();
    t_adc();
    t_reset();
    end_sim();
  end
endmodule // tb

bind pmrs_top pmrs_top_asserts i_pmrs_top_asserts (.CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
  .PSTRB_I(PSTRB_I), .ADC_MODE_I(ADC_MODE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
  .PRDATA_O(PRDATA_O), .PIN46_PAD_O(PIN46_PAD_O), .PIN47_PAD_O(PIN47_PAD_O),
  .PORT0_RAIL_BITS_O(PORT0_RAIL_BITS_O), .PORT1_RAIL_BITS_O(PORT1_RAIL_BITS_O),
  .PORT2_RAIL_BITS_O(PORT2_RAIL_BITS_O), .PORT3_RAIL_BITS_O(PORT3_RAIL_BITS_O),
  .PORT4_RAIL_BITS_O(PORT4_RAIL_BITS_O));
`default_nettype wire
